// ==== rtl/slps_regs.sv ====
// serial link parameter and status register bank with APB slave
// assumes link status and pll lock inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module slps_regs #(
	parameter int ADDR_W = 14
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_up,
	input  wire logic        sync_n,
	input  wire logic        sysref_realign,
	input  wire logic        sysref_event,
	input  wire logic        serializer_pll_lock,
	input  wire logic        converter_pll_lock,
	input  wire logic        comma_opportunity,
	input  wire logic        mode_8b10b,
	output logic      [7:0]  ila_identifier_value,
	output logic      [7:0]  end_comma,
	output logic             end_comma_valid,
	output logic             link_encoder_enable,
	output logic      [7:0]  channel_pair_enable_reg,
	output logic             irq
);
	// the index decode reads address bits 13:2
	if (ADDR_W < 14) begin : g_addr_check
		$error("ADDR_W too small for register map");
	end

	typedef struct packed {
		logic [7:0] ila_identifier;
		logic [7:0] frame_end_character;
		logic [7:0] channel_pair_enable;
		logic [7:0] irq_mask;
		logic       enc_en;
		logic [7:0] sticky;
		logic [31:0] rdata;
		logic [7:0] comma;
		logic       comma_vld;
		logic [5:0] s1;
		logic [5:0] s2;
		logic       ev_d;
		logic       ra_d;
		logic       ins;
	} slps_state_t;

	slps_state_t st;
	slps_state_t next_st;

	function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[13:2];
	endfunction

	logic       acc;
	logic       wr;
	logic       rd_setup;
	logic [11:0] idx;
	logic       mapped;
	logic [7:0] status_view;
	logic       ev_rise;
	logic       ra_rise;

	assign acc = psel & penable;
	assign wr  = acc & pwrite & pstrb[0] & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign idx = reg_index(paddr);
	assign mapped = (paddr[1:0] == 2'h0) && (idx >= slps_pkg::IDX_ILA_IDENTIFIER)
		&& (idx <= slps_pkg::IDX_IRQ_MASK);
	// s2 order: 5 link_up,4 sync_n,3 sysref_evt,2 realign,1 spll,0 cpll
	assign ev_rise = st.s2[3] & ~st.ev_d;
	assign ra_rise = st.s2[2] & ~st.ra_d;
	always_comb begin
		status_view = 8'h00;
		status_view[slps_pkg::BIT_LINK_UP]    = st.s2[5];
		status_view[slps_pkg::BIT_SYNC_STATE] = st.s2[4];
		status_view[slps_pkg::BIT_REALIGNED]  = st.sticky[slps_pkg::BIT_REALIGNED];
		status_view[slps_pkg::BIT_PHASE_SET]  = st.sticky[slps_pkg::BIT_PHASE_SET];
		status_view[slps_pkg::BIT_SPLL_LOCK]  = st.s2[1];
		status_view[slps_pkg::BIT_CPLL_LOCK]  = st.s2[0];
	end

	always_comb begin
		next_st = st;
		next_st.s1 = {link_up, sync_n, sysref_event, sysref_realign,
			serializer_pll_lock, converter_pll_lock};
		next_st.s2 = st.s1;
		next_st.ev_d = st.s2[3];
		next_st.ra_d = st.s2[2];
		// only in 8B/10B modes, only at an opportunity
		next_st.ins = comma_opportunity & mode_8b10b & st.enc_en;
		if (wr) begin
			case (idx)
				slps_pkg::IDX_ILA_IDENTIFIER: next_st.ila_identifier = pwdata[7:0];
				// reserved high bits stored as written; host keeps them zero
				slps_pkg::IDX_FRAME_END_CHAR: next_st.frame_end_character = pwdata[7:0];
				slps_pkg::IDX_CHANNEL_PAIR_EN: next_st.channel_pair_enable = pwdata[7:0];
				slps_pkg::IDX_LINK_CONTROL: next_st.enc_en = pwdata[0];
				slps_pkg::IDX_IRQ_MASK: next_st.irq_mask = pwdata[7:0] & slps_pkg::STICKY_MASK;
				slps_pkg::IDX_LINK_STATUS:
					next_st.sticky = st.sticky & ~(pwdata[7:0] & slps_pkg::STICKY_MASK);
				default: ;
			endcase
		end
		// set wins over a simultaneous clear
		if (ra_rise)
			next_st.sticky[slps_pkg::BIT_REALIGNED] = 1'b1;
		// armed only while enabled and not yet set since enable
		if (ev_rise && st.enc_en && !st.comma_vld)
			next_st.sticky[slps_pkg::BIT_PHASE_SET] = 1'b1;
		if (wr && idx == slps_pkg::IDX_LINK_CONTROL && pwdata[0] && !st.enc_en)
			next_st.comma_vld = 1'b0;
		else if (ev_rise && st.enc_en)
			next_st.comma_vld = 1'b1;
		// loaded in the setup cycle so that data stands at the access edge
		if (rd_setup) begin
			next_st.rdata = 32'h0000_0000;
			if (mapped) begin
				case (idx)
					slps_pkg::IDX_ILA_IDENTIFIER: next_st.rdata[7:0] = st.ila_identifier;
					slps_pkg::IDX_FRAME_END_CHAR: next_st.rdata[7:0] = st.frame_end_character;
					slps_pkg::IDX_LINK_STATUS: next_st.rdata[7:0] = status_view;
					slps_pkg::IDX_CHANNEL_PAIR_EN: next_st.rdata[7:0] = st.channel_pair_enable;
					slps_pkg::IDX_LINK_CONTROL: next_st.rdata[0] = st.enc_en;
					slps_pkg::IDX_IRQ_MASK: next_st.rdata[7:0] = st.irq_mask;
					default: ;
				endcase
			end
		end
		case (slps_pkg::slps_fch_t'(st.frame_end_character[1:0] & slps_pkg::FCH_SEL_MASK))
			slps_pkg::SLPS_FCH_K287: next_st.comma = slps_pkg::K28_7;
			slps_pkg::SLPS_FCH_K281: next_st.comma = slps_pkg::K28_1;
			slps_pkg::SLPS_FCH_K285: next_st.comma = slps_pkg::K28_5;
			default: next_st.comma = slps_pkg::K28_7;
		endcase
	end

	// comma_vld doubles as the phase-set arm flag, cleared when enable is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{ila_identifier: slps_pkg::RST_ILA_IDENTIFIER,
				frame_end_character: slps_pkg::RST_FRAME_END_CHAR,
				channel_pair_enable: slps_pkg::RST_CHANNEL_PAIR_EN,
				irq_mask: slps_pkg::RST_IRQ_MASK, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign ila_identifier_value = st.ila_identifier;
	assign end_comma = st.comma;
	assign end_comma_valid = st.ins;
	assign link_encoder_enable = st.enc_en;
	assign channel_pair_enable_reg = st.channel_pair_enable;
	assign irq = |(st.sticky & st.irq_mask);

	property p_realign_sets;
		@(posedge pclk) disable iff (!presetn)
		ra_rise |=> st.sticky[slps_pkg::BIT_REALIGNED];
	endproperty
	a_realign_sets: assert property (p_realign_sets) else $error("realign not sticky");

	property p_phase_sets;
		@(posedge pclk) disable iff (!presetn)
		(ev_rise && st.enc_en && !st.comma_vld) |=> st.sticky[slps_pkg::BIT_PHASE_SET];
	endproperty
	a_phase_sets: assert property (p_phase_sets) else $error("phase set missed");

	property p_phase_needs_enable;
		@(posedge pclk) disable iff (!presetn)
		$rose(st.sticky[slps_pkg::BIT_PHASE_SET]) |-> $past(st.enc_en);
	endproperty
	a_phase_needs_enable: assert property (p_phase_needs_enable) else $error("phase set while off");

	property p_link_up_view;
		@(posedge pclk) disable iff (!presetn)
		status_view[slps_pkg::BIT_LINK_UP] == $past(link_up, 2);
	endproperty
	a_link_up_view: assert property (p_link_up_view) else $error("link up wrong");

	property p_sync_view;
		@(posedge pclk) disable iff (!presetn)
		status_view[slps_pkg::BIT_SYNC_STATE] == $past(sync_n, 2);
	endproperty
	a_sync_view: assert property (p_sync_view) else $error("sync state wrong");

	property p_spll_view;
		@(posedge pclk) disable iff (!presetn)
		status_view[slps_pkg::BIT_SPLL_LOCK] == $past(serializer_pll_lock, 2);
	endproperty
	a_spll_view: assert property (p_spll_view) else $error("spll view wrong");

	property p_cpll_view;
		@(posedge pclk) disable iff (!presetn)
		status_view[slps_pkg::BIT_CPLL_LOCK] == $past(converter_pll_lock, 2);
	endproperty
	a_cpll_view: assert property (p_cpll_view) else $error("cpll view wrong");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		status_view[7] == 1'b0 && status_view[1] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_comma_sel;
		@(posedge pclk) disable iff (!presetn)
		(st.frame_end_character[1:0] == 2'h1) |=> (st.comma == slps_pkg::K28_1);
	endproperty
	a_comma_sel: assert property (p_comma_sel) else $error("comma select wrong");

	property p_insert_8b10b;
		@(posedge pclk) disable iff (!presetn)
		end_comma_valid |-> $past(mode_8b10b) && $past(comma_opportunity);
	endproperty
	a_insert_8b10b: assert property (p_insert_8b10b) else $error("comma outside 8b10b");

	property p_id_out;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == slps_pkg::IDX_ILA_IDENTIFIER) |=> ila_identifier_value == $past(pwdata[7:0]);
	endproperty
	a_id_out: assert property (p_id_out) else $error("identifier not output");

	// pin edge, two synchroniser stages, edge detect, then the sticky bit
	sequence s_realign_pin;
		$rose(sysref_realign);
	endsequence
	sequence s_realign_seen;
		##3 st.sticky[slps_pkg::BIT_REALIGNED];
	endsequence
	property p_realign_path;
		@(posedge pclk) disable iff (!presetn)
		s_realign_pin |-> s_realign_seen;
	endproperty
	a_realign_path: assert property (p_realign_path) else $error("realign pin lost");

	sequence s_realign_clear;
		wr && idx == slps_pkg::IDX_LINK_STATUS && pwdata[slps_pkg::BIT_REALIGNED] && !ra_rise;
	endsequence
	property p_realign_clears;
		@(posedge pclk) disable iff (!presetn)
		s_realign_clear |=> !st.sticky[slps_pkg::BIT_REALIGNED];
	endproperty
	a_realign_clears: assert property (p_realign_clears) else $error("realign not cleared");

	property p_status_read;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && mapped && idx == slps_pkg::IDX_LINK_STATUS)
			|-> prdata[7:0] == $past(status_view);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_irq_follows;
		@(posedge pclk) disable iff (!presetn)
		(ra_rise && st.irq_mask[slps_pkg::BIT_REALIGNED] && !wr) |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

	property p_comma_k285;
		@(posedge pclk) disable iff (!presetn)
		(st.frame_end_character[1:0] == 2'h2) |=> (st.comma == slps_pkg::K28_5);
	endproperty
	a_comma_k285: assert property (p_comma_k285) else $error("comma k285 wrong");

	property p_comma_k287;
		@(posedge pclk) disable iff (!presetn)
		(st.frame_end_character[1:0] == 2'h0 || st.frame_end_character[1:0] == 2'h3)
			|=> (st.comma == slps_pkg::K28_7);
	endproperty
	a_comma_k287: assert property (p_comma_k287) else $error("comma k287 wrong");

	property p_insert_on_opp;
		@(posedge pclk) disable iff (!presetn)
		(comma_opportunity && mode_8b10b && st.enc_en) |=> end_comma_valid;
	endproperty
	a_insert_on_opp: assert property (p_insert_on_opp) else $error("comma not inserted");

	property p_phase_once;
		@(posedge pclk) disable iff (!presetn)
		(ev_rise && st.comma_vld && !st.sticky[slps_pkg::BIT_PHASE_SET]) |=> !st.sticky[slps_pkg::BIT_PHASE_SET];
	endproperty
	a_phase_once: assert property (p_phase_once) else $error("phase set twice");
endmodule
`default_nettype wire

// ==== rtl/slps_pkg.sv ====
// register map constants for the serial link parameter and status bank
// assumes an APB slave with 32-bit data, one register per multiframe_phase_set word
package slps_pkg;
	// printed offsets are not multiples of four: indices, byte address = 4*index
	localparam logic [11:0] IDX_ILA_IDENTIFIER  = 12'h206;
	localparam logic [11:0] IDX_FRAME_END_CHAR  = 12'h207;
	localparam logic [11:0] IDX_LINK_STATUS     = 12'h208;
	localparam logic [11:0] IDX_CHANNEL_PAIR_EN = 12'h209;
	localparam logic [11:0] IDX_LINK_CONTROL    = 12'h20A;
	localparam logic [11:0] IDX_IRQ_MASK        = 12'h20B;
	localparam logic [7:0] RST_ILA_IDENTIFIER  = 8'h00;
	localparam logic [7:0] RST_FRAME_END_CHAR  = 8'h00;
	localparam logic [7:0] RST_CHANNEL_PAIR_EN = 8'h03;
	localparam logic [7:0] RST_IRQ_MASK        = 8'h00;
	localparam int BIT_LINK_UP     = 6;
	localparam int BIT_SYNC_STATE  = 5;
	localparam int BIT_REALIGNED   = 4;
	localparam int BIT_PHASE_SET   = 3;
	localparam int BIT_SPLL_LOCK   = 2;
	localparam int BIT_CPLL_LOCK   = 0;
	localparam logic [7:0] STICKY_MASK = 8'h18;
	localparam logic [7:0] STATUS_MASK = 8'h7D;
	localparam logic [1:0] FCH_SEL_MASK = 2'h3;
	// comma characters as 8-bit K code values
	localparam logic [7:0] K28_7 = 8'hFC;
	localparam logic [7:0] K28_1 = 8'h3C;
	localparam logic [7:0] K28_5 = 8'hBC;
	typedef enum logic [1:0] {SLPS_FCH_K287, SLPS_FCH_K281, SLPS_FCH_K285, SLPS_FCH_RSVD} slps_fch_t;
endpackage

// ==== dv/slps_link_model.sv ====
// link side stand-in: stretches sysref requests into level pulses
// assumes one-cycle request strobes from the bench on pclk
`timescale 1ns/1ps
`default_nettype none
module slps_link_model (
	input  wire logic pclk,
	input  wire logic fire_realign,
	input  wire logic fire_event,
	output logic      sysref_realign,
	output logic      sysref_event
);
	int cnt_r = 0;
	int cnt_e = 0;
	// held 3 cycles so the 2-FF synchroniser cannot miss it
	always_ff @(posedge pclk) begin
		cnt_r <= fire_realign ? 3 : (cnt_r > 0 ? cnt_r - 1 : 0);
		cnt_e <= fire_event ? 3 : (cnt_e > 0 ? cnt_e - 1 : 0);
	end
	assign sysref_realign = cnt_r > 0;
	assign sysref_event   = cnt_e > 0;
endmodule
`default_nettype wire

// ==== dv/slps_regs_tb.sv ====
// self-checking bench for the link parameter and status bank
// assumes zero-wait APB slave with registered read data
`timescale 1ns/1ps
`default_nettype none
module slps_regs_tb;
	logic        pclk, presetn, psel, penable, pwrite, lnk, syn, spll, cpll;
	logic        copp, m8, f_r, f_e, sr_r, sr_e, pready, pslverr, ev, enc, irq, serr;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [3:0]  pstrb;
	logic [7:0]  ila, ec, cpe, stk;
	int          err_count, samples_checked, i;
	int          kc[$];
	slps_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_up(lnk), .sync_n(syn),
		.sysref_realign(sr_r), .sysref_event(sr_e), .serializer_pll_lock(spll),
		.converter_pll_lock(cpll), .comma_opportunity(copp), .mode_8b10b(m8),
		.ila_identifier_value(ila), .end_comma(ec), .end_comma_valid(ev),
		.link_encoder_enable(enc), .channel_pair_enable_reg(cpe), .irq(irq));
	slps_link_model link (.pclk(pclk), .fire_realign(f_r), .fire_event(f_e),
		.sysref_realign(sr_r), .sysref_event(sr_e));
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// pready is tied high, so this wait ends at its first edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		serr = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// written outputs update at the access edge or one edge after it
	task automatic settle;
		repeat (2) @(negedge pclk);
	endtask
	task automatic pulse(input bit realign);
		@(posedge pclk);
		if (realign)
			f_r <= 1;
		else
			f_e <= 1;
		@(posedge pclk);
		f_r <= 0;
		f_e <= 0;
		repeat (8) @(posedge pclk);
	endtask
	task automatic rd_st;
		apb(0, slps_pkg::IDX_LINK_STATUS, 0);
		chk(rd, {24'h0, 1'b0, lnk, syn, stk[4], stk[3], spll, 1'b0, cpll});
	endtask
	task automatic summarize;
		$display("errors=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, lnk, syn, spll, cpll, copp, m8, f_r, f_e} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		stk = '0;
		err_count = 0;
		samples_checked = 0;
		v = $urandom(54);
		repeat (20) @(posedge pclk);
		presetn <= 1;
		// comma codes per select value, reserved 3 falls back to K28.7
		kc = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
		apb(0, slps_pkg::IDX_CHANNEL_PAIR_EN, 0);
		chk(rd, 32'h03);
		chk(ec, 8'hFC);
		v = {24'h0, 8'($urandom)};
		apb(1, slps_pkg::IDX_ILA_IDENTIFIER, v);
		apb(1, slps_pkg::IDX_CHANNEL_PAIR_EN, 32'h01);
		apb(0, slps_pkg::IDX_ILA_IDENTIFIER, 0);
		chk(rd, v);
		chk(ila, v);
		chk(cpe, 8'h01);
		for (i = 0; i < 4; i++) begin
			apb(1, slps_pkg::IDX_FRAME_END_CHAR, i);
			settle;
			chk(ec, kc[i]);
		end
		apb(1, slps_pkg::IDX_FRAME_END_CHAR, 0);
		apb(1, slps_pkg::IDX_IRQ_MASK, 32'h18);
		apb(0, slps_pkg::IDX_IRQ_MASK, 0);
		chk(rd, 32'h18);
		apb(1, slps_pkg::IDX_LINK_CONTROL, 1);
		settle;
		chk(enc, 1);
		chk(ec, 8'hFC);
		for (i = 0; i < 2; i++) begin
			@(posedge pclk);
			copp <= 1;
			m8 <= i[0];
			@(posedge pclk);
			copp <= 0;
			@(negedge pclk);
			chk(ev, i);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge pclk);
			{lnk, syn, spll, cpll} <= 4'($urandom);
			repeat (4) @(posedge pclk);
			rd_st;
		end
		// ones to reserved and level bits must change nothing
		apb(1, slps_pkg::IDX_LINK_STATUS, 32'hE7);
		rd_st;
		pulse(0);
		stk[3] = 1;
		rd_st;
		pulse(1);
		stk[4] = 1;
		rd_st;
		chk(irq, 1);
		apb(1, slps_pkg::IDX_IRQ_MASK, 0);
		settle;
		chk(irq, 0);
		apb(1, slps_pkg::IDX_LINK_STATUS, 32'h18);
		stk = '0;
		rd_st;
		apb(1, slps_pkg::IDX_IRQ_MASK, 32'h18);
		pulse(0);
		rd_st;
		chk(irq, 0);
		// re-enabling arms the phase flag again
		apb(1, slps_pkg::IDX_LINK_CONTROL, 0);
		apb(1, slps_pkg::IDX_LINK_CONTROL, 1);
		pulse(0);
		stk[3] = 1;
		rd_st;
		chk(irq, 1);
		apb(0, 12'h300, 0);
		chk(serr, 1);
		chk(rd, 0);
		summarize;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		summarize;
	end
endmodule
`default_nettype wire
